// ### rtl/icc_pkg.sv
// Shared constants and types for the I/O channel chaining controller.
// Assumes one sys_clk domain; descriptors are two 32-bit words.
package icc_pkg;

    localparam int ADDR_W = 24;
    localparam int CNT_W  = 16;

    // Flag positions in descriptor word 1
    localparam int FLG_DC   = 0;
    localparam int FLG_CC   = 1;
    localparam int FLG_SIL  = 2;
    localparam int FLG_SKIP = 3;
    localparam int FLG_PROGRAM_INTERRUPT_FLAG = 4;

    // Controller status byte layout
    localparam int ST_ATTN = 7;
    localparam int ST_SM   = 6;
    localparam int ST_CE   = 5;
    localparam int ST_DE   = 4;
    localparam int ST_UC   = 3;
    localparam int ST_UX   = 2;

    localparam logic [ADDR_W-1:0] DESC_STEP = 24'h00_0008;
    localparam logic [ADDR_W-1:0] DESC_SKIP = 24'h00_0010;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_LIST  = 8'h04;
    localparam logic [7:0] REG_STAT0 = 8'h08;
    localparam logic [7:0] REG_STAT1 = 8'h0C;
    localparam logic [7:0] REG_STATE = 8'h10;
    localparam int CTRL_START = 0;
    localparam int STAT1_PROGRAM_INTERRUPT_FLAG = 16;

    typedef enum logic [2:0] {
        CK_CCTL, CK_SENSE, CK_BRANCH, CK_RDBK, CK_WRITE, CK_READ, CK_CTRL, CK_UNDEF
    } icc_cmd_t;

    typedef enum logic [1:0] {ICC_IDLE, ICC_FETCH, ICC_ISSUE, ICC_XFER} icc_phase_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } icc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } icc_apb_rsp_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } icc_mem_wr_t;

    typedef struct packed {
        icc_phase_t        phase;
        icc_apb_rsp_t      apb;
        logic [ADDR_W-1:0] list_addr;
        logic [ADDR_W-1:0] cur_addr;
        logic [ADDR_W-1:0] desc_addr;
        logic              desc_req;
        logic [7:0]        subaddr;
        logic [7:0]        cmd;
        logic [7:0]        flags;
        logic [CNT_W-1:0]  count;
        logic [ADDR_W-1:0] data_addr;
        logic              dchain;
        logic              ce_seen;
        logic              prog_chk;
        logic              program_interrupt_flag_pend;
        logic              end_pend;
        logic              ended;
        logic [7:0]        ctrl_stat;
        logic              dev_cmd_valid;
        logic              dev_data_ready;
        icc_mem_wr_t       mem_wr;
        logic              irq;
    } icc_state_t;

endpackage : icc_pkg

// ### rtl/icc_chain_ctrl.sv
// Chaining, skip and program-interrupt control of one I/O channel.
// Assumes descriptor memory, controller and processor logic on sys_clk.
`timescale 1ns/100ps

module icc_chain_ctrl #(
    parameter logic [23:0] MEM_TOP = 24'hFF_FFFF
)(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire icc_pkg::icc_apb_req_t apb_req,
    output      icc_pkg::icc_apb_rsp_t apb_rsp,
    output      logic                  desc_req,
    output      logic [23:0]           desc_addr,
    input  wire logic                  desc_ack,
    input  wire logic [31:0]           desc_word0,
    input  wire logic [31:0]           desc_word1,
    output      logic                  dev_cmd_valid,
    output      logic [7:0]            dev_cmd,
    input  wire logic                  dev_data_valid,
    input  wire logic [7:0]            dev_data,
    output      logic                  dev_data_ready,
    input  wire logic                  dev_status_valid,
    input  wire logic [7:0]            dev_status,
    output      icc_pkg::icc_mem_wr_t  mem_wr,
    output      logic                  cpu_irq,
    input  wire logic                  cpu_iack,
    input  wire logic                  cpu_iack_busy
);
    import icc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Command decode

    function automatic icc_cmd_t cmd_kind(input logic [7:0] c);
        icc_cmd_t k;
        k = CK_UNDEF;
        unique case (c[1:0])
            2'b01: k = CK_WRITE;
            2'b10: k = CK_READ;
            2'b11: k = CK_CTRL;
            2'b00:
            begin
                unique case (c[3:2])
                    2'b00: k = CK_CCTL;
                    2'b01: k = CK_SENSE;
                    2'b11: k = CK_RDBK;
                    2'b10: k = (c[6:4] == 3'b000) ? CK_BRANCH : CK_UNDEF;
                endcase
            end
        endcase
        return k;
    endfunction : cmd_kind

    // Flags masked by what each command allows
    function automatic logic [7:0] eff_flags(input logic [7:0] c, input logic [7:0] f);
        logic [7:0] m;
        m = 8'h00;
        unique case (cmd_kind(c))
            CK_READ, CK_RDBK:           m = 8'h1F;
            CK_WRITE, CK_CTRL, CK_SENSE: m = 8'h17;
            CK_CCTL:                    m = 8'h06;
            CK_BRANCH, CK_UNDEF:        m = 8'h00;
        endcase
        return f & m;
    endfunction : eff_flags

    function automatic logic is_input(input logic [7:0] c);
        icc_cmd_t k;
        k = cmd_kind(c);
        return (k == CK_READ) || (k == CK_RDBK) || (k == CK_SENSE);
    endfunction : is_input

    function automatic logic is_immediate(input logic [7:0] c);
        icc_cmd_t k;
        k = cmd_kind(c);
        return (k == CK_CCTL) || (k == CK_CTRL);
    endfunction : is_immediate

    ////////////////////////////////////////////////////////////////////////
    // State

    icc_state_t s;
    icc_state_t next_s;

    logic [7:0]  fl;
    logic        skip_now;
    logic        accept;
    logic        st_de;
    logic        st_ce;
    logic        st_sm;
    logic        st_bad;
    logic        il_eff;
    logic        unusual;
    logic        chain_ok;
    logic [31:0] stat0_w;
    logic [31:0] stat1_w;
    logic [7:0]  new_cmd;

    always_comb
    begin
        fl       = eff_flags(s.cmd, s.flags);
        skip_now = fl[FLG_SKIP] && is_input(s.cmd);
        accept   = dev_data_valid && s.dev_data_ready;
        st_de    = dev_status[ST_DE];
        st_ce    = dev_status[ST_CE];
        st_sm    = dev_status[ST_SM];
        st_bad   = dev_status[ST_ATTN] | dev_status[ST_UC] | dev_status[ST_UX];
        // Immediate ops and cc+sil hide length errors; sil is dead under dc
        il_eff   = (s.count != '0) && !is_immediate(s.cmd)
                   && !(fl[FLG_CC] && fl[FLG_SIL] && !fl[FLG_DC]);
        unusual  = st_bad || s.prog_chk || il_eff;
        // Lone device end is valid only after an earlier channel end
        chain_ok = st_de && (st_ce || s.ce_seen) && !unusual;
        stat0_w  = {s.subaddr, s.cur_addr + DESC_STEP};
        stat1_w  = '0;
        stat1_w[STAT1_PROGRAM_INTERRUPT_FLAG] = s.program_interrupt_flag_pend;
        if (s.ended)
        begin
            stat1_w[31:24] = s.ctrl_stat;
            stat1_w[15:0]  = s.count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        next_s = s;
        new_cmd = desc_word0[31:24];
        next_s.dev_cmd_valid = 1'b0;
        next_s.mem_wr.valid  = 1'b0;
        next_s.apb.pready    = 1'b0;
        next_s.apb.pslverr   = 1'b0;

        // Interrupt acknowledge clears first so new events win
        if (cpu_iack)
        begin
            next_s.program_interrupt_flag_pend = 1'b0;
            next_s.end_pend  = 1'b0;
        end

        // Register access: answer one cycle into the access phase
        if (apb_req.psel && apb_req.penable && !s.apb.pready)
        begin
            next_s.apb.pready = 1'b1;
            next_s.apb.prdata = '0;
            unique case (apb_req.paddr)
                REG_CTRL:  next_s.apb.prdata = {16'h0000, s.subaddr, 8'h00};
                REG_LIST:  next_s.apb.prdata = {8'h00, s.list_addr};
                REG_STAT0: next_s.apb.prdata = stat0_w;
                REG_STAT1: next_s.apb.prdata = stat1_w;
                REG_STATE:
                    next_s.apb.prdata = {26'h000_0000, s.phase, s.dchain, s.ended, s.irq, s.program_interrupt_flag_pend};
                default:   next_s.apb.pslverr = 1'b1;
            endcase
        end

        // Writes land at the edge where the master sees pready high
        if (apb_req.psel && apb_req.penable && apb_req.pwrite && s.apb.pready)
        begin
            if (apb_req.paddr == REG_CTRL)
            begin
                next_s.subaddr = apb_req.pwdata[15:8];
                if (apb_req.pwdata[CTRL_START] && s.phase == ICC_IDLE)
                begin
                    next_s.phase     = ICC_FETCH;
                    next_s.desc_req  = 1'b1;
                    next_s.desc_addr = s.list_addr;
                    next_s.cur_addr  = s.list_addr;
                    next_s.dchain    = 1'b0;
                    next_s.ended     = 1'b0;
                    next_s.ce_seen   = 1'b0;
                    next_s.prog_chk  = 1'b0;
                    next_s.flags     = 8'h00;
                end
            end
            if (apb_req.paddr == REG_LIST)
                next_s.list_addr = apb_req.pwdata[ADDR_W-1:0];
        end

        unique case (s.phase)
            ICC_IDLE: ;
            ICC_FETCH:
            begin
                if (desc_ack)
                begin
                    if (cmd_kind(new_cmd) == CK_BRANCH)
                    begin
                        // Flags and pending interrupt pass through untouched
                        next_s.cur_addr  = desc_word0[ADDR_W-1:0];
                        next_s.desc_addr = desc_word0[ADDR_W-1:0];
                    end
                    else
                    begin
                        next_s.desc_req  = 1'b0;
                        next_s.flags     = desc_word1[31:24];
                        next_s.count     = desc_word1[CNT_W-1:0];
                        next_s.data_addr = desc_word0[ADDR_W-1:0];
                        if (s.dchain)
                            next_s.phase = ICC_XFER;
                        else
                        begin
                            next_s.cmd     = new_cmd;
                            next_s.phase   = ICC_ISSUE;
                            next_s.ce_seen = 1'b0;
                        end
                    end
                end
            end
            ICC_ISSUE:
            begin
                // Modifier bits travel to the controller unchanged
                next_s.dev_cmd_valid = 1'b1;
                next_s.phase         = ICC_XFER;
            end
            ICC_XFER:
            begin
                if (accept)
                begin
                    next_s.count = s.count - 1'b1;
                    next_s.data_addr = (cmd_kind(s.cmd) == CK_RDBK) ?
                                       s.data_addr - 1'b1 : s.data_addr + 1'b1;
                    if (is_input(s.cmd) && !skip_now)
                    begin
                        if (s.data_addr > MEM_TOP)
                            next_s.prog_chk = 1'b1;
                        else
                        begin
                            next_s.mem_wr.valid = 1'b1;
                            next_s.mem_wr.addr  = s.data_addr;
                            next_s.mem_wr.data  = dev_data;
                        end
                    end
                    if (next_s.count == '0 && fl[FLG_DC])
                    begin
                        if (fl[FLG_PROGRAM_INTERRUPT_FLAG])
                            next_s.program_interrupt_flag_pend = 1'b1;
                        next_s.dchain    = 1'b1;
                        next_s.cur_addr  = s.cur_addr + DESC_STEP;
                        next_s.desc_addr = s.cur_addr + DESC_STEP;
                        next_s.desc_req  = 1'b1;
                        next_s.phase     = ICC_FETCH;
                    end
                end
                else if (dev_status_valid)
                begin
                    if (st_ce)
                        next_s.ce_seen = 1'b1;
                    if (fl[FLG_CC] && chain_ok)
                    begin
                        if (fl[FLG_PROGRAM_INTERRUPT_FLAG])
                            next_s.program_interrupt_flag_pend = 1'b1;
                        next_s.cur_addr  = s.cur_addr + (st_sm ? DESC_SKIP : DESC_STEP);
                        next_s.desc_addr = s.cur_addr + (st_sm ? DESC_SKIP : DESC_STEP);
                        next_s.desc_req  = 1'b1;
                        next_s.dchain    = 1'b0;
                        next_s.phase     = ICC_FETCH;
                    end
                    else if (unusual || st_de || !fl[FLG_CC])
                    begin
                        next_s.ctrl_stat = dev_status;
                        next_s.ended     = 1'b1;
                        next_s.end_pend  = 1'b1;
                        next_s.phase     = ICC_IDLE;
                    end
                end
            end
        endcase

        next_s.dev_data_ready = (next_s.phase == ICC_XFER) && (next_s.count != '0)
                                && !cpu_iack_busy;
        next_s.irq = next_s.program_interrupt_flag_pend || next_s.end_pend;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign apb_rsp        = s.apb;
    assign desc_req       = s.desc_req;
    assign desc_addr      = s.desc_addr;
    assign dev_cmd_valid  = s.dev_cmd_valid;
    assign dev_cmd        = s.cmd;
    assign dev_data_ready = s.dev_data_ready;
    assign mem_wr         = s.mem_wr;
    assign cpu_irq        = s.irq;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_SKIP_NO_WRITE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (accept && skip_now && s.phase == ICC_XFER) |=> !s.mem_wr.valid)
        else $error("memory written while skipping");

    AST_SKIP_COUNT: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (accept && skip_now && s.phase == ICC_XFER) |=> s.count == $past(s.count) - 16'h0001)
        else $error("skip did not decrement count");

    AST_MODIFIER_SKIP16: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (s.phase == ICC_XFER && !accept && dev_status_valid && fl[FLG_CC] && chain_ok && st_sm)
        |=> s.desc_req && s.desc_addr == $past(s.cur_addr) + DESC_SKIP)
        else $error("status modifier did not skip a descriptor");

    AST_NO_FETCH_UNUSUAL: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (s.phase == ICC_XFER && !accept && dev_status_valid && unusual)
        |=> s.phase == ICC_IDLE && !s.desc_req && s.end_pend)
        else $error("fetch after unusual status");

    AST_CHAIN_NEEDS_DE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (s.phase == ICC_XFER && !accept && dev_status_valid && !st_de)
        |=> !(s.phase == ICC_FETCH && !s.dchain))
        else $error("command chained without device end");

    AST_PROGRAM_INTERRUPT_FLAG_AT_ZERO: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (s.phase == ICC_XFER && accept && s.count == 16'h0001 && fl[FLG_DC] && fl[FLG_PROGRAM_INTERRUPT_FLAG])
        |=> s.program_interrupt_flag_pend ##1 s.irq)
        else $error("program interrupt not posted at zero count");

    AST_EARLY_STATUS: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (apb_req.psel && apb_req.penable && !s.apb.pready && apb_req.paddr == REG_STAT1 && !s.ended)
        |=> s.apb.prdata[31:17] == '0 && s.apb.prdata[15:0] == '0)
        else $error("early status carries ending fields");

    AST_IACK_STALL: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        cpu_iack_busy |=> !s.dev_data_ready)
        else $error("data served during acknowledge");

    AST_CMD_KEPT: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (s.phase == ICC_FETCH && s.dchain && desc_ack) |=> $stable(s.cmd) && !s.dev_cmd_valid)
        else $error("data chaining changed the command");

    AST_PROGRAM_INTERRUPT_FLAG_CARRY: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (s.phase == ICC_FETCH && s.program_interrupt_flag_pend && !cpu_iack) |=> s.program_interrupt_flag_pend)
        else $error("pending program interrupt lost in chaining");

endmodule : icc_chain_ctrl

// ### testbench/icc_dev_model.sv
// Behavioural peripheral controller facing the chaining block.
// Assumes one command at a time on sys_clk; modifier bit 7 picks the status.
`timescale 1ns/100ps

module icc_dev_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       dev_cmd_valid,
    input  wire logic [7:0] dev_cmd,
    input  wire logic       dev_data_ready,
    input  wire logic [7:0] n_bytes,
    input  wire logic [7:0] status_hi,
    input  wire logic [7:0] status_lo,
    output      logic       dev_data_valid,
    output      logic [7:0] dev_data,
    output      logic       dev_status_valid,
    output      logic [7:0] dev_status
);
    logic       active;
    logic [7:0] left;
    logic [7:0] seq;
    logic [7:0] st;
    assign st         = dev_cmd[7] ? status_hi : status_lo;
    // Idle lines show an inverted pattern so stale values never pass
    assign dev_data   = dev_data_valid ? seq : ~seq;
    assign dev_status = dev_status_valid ? st : ~st;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active           <= 1'b0;
            left             <= 8'h00;
            seq              <= 8'h00;
            dev_data_valid   <= 1'b0;
            dev_status_valid <= 1'b0;
        end
        else
        begin
            dev_status_valid <= 1'b0;
            if (dev_cmd_valid)
            begin
                active         <= 1'b1;
                left           <= n_bytes;
                seq            <= 8'hA0;
                dev_data_valid <= (n_bytes != 8'h00);
            end
            else if (active && dev_data_valid && dev_data_ready)
            begin
                left           <= left - 8'h01;
                seq            <= seq + 8'h01;
                dev_data_valid <= (left > 8'h01);
            end
            else if (active && left == 8'h00 && !dev_data_valid)
            begin
                // Status only after all bytes, never with one
                dev_status_valid <= 1'b1;
                active           <= 1'b0;
            end
        end
    end
endmodule : icc_dev_model

// ### testbench/icc_chain_ctrl_tb.sv
// Self-checking bench for the chaining controller.
// Assumes the device model file; the bench serves descriptors and the APB master.
`timescale 1ns/100ps

module icc_chain_ctrl_tb;
    import icc_pkg::*;
    `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("BAD %0t mismatch", $time); end end
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    icc_apb_req_t apb_req = '0;
    icc_apb_rsp_t apb_rsp;
    logic desc_req, desc_ack = 1'b0, dev_cmd_valid, dev_data_valid, dev_data_ready, dev_status_valid, cpu_irq;
    logic [23:0] desc_addr;
    logic [31:0] desc_word0 = '0, desc_word1 = '0, rd;
    logic [7:0] dev_cmd, dev_data, dev_status, n_bytes = 8'h00, status_hi = 8'h00, status_lo = 8'h00;
    logic cpu_iack = 1'b0, cpu_iack_busy = 1'b0, err;
    icc_mem_wr_t mem_wr;
    logic [63:0] desc_tab [0:31];
    logic [23:0] fetch_q [$];
    int n_fail = 0, n_checks = 0, n_wr = 0;
    logic [23:0] wr_addr;
    logic [7:0] wr_data;
    always #2 sys_clk = ~sys_clk;
    icc_chain_ctrl #(.MEM_TOP(24'h00_0FFF)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .desc_req(desc_req), .desc_addr(desc_addr), .desc_ack(desc_ack),
        .desc_word0(desc_word0), .desc_word1(desc_word1), .dev_cmd_valid(dev_cmd_valid), .dev_cmd(dev_cmd),
        .dev_data_valid(dev_data_valid), .dev_data(dev_data), .dev_data_ready(dev_data_ready),
        .dev_status_valid(dev_status_valid), .dev_status(dev_status), .mem_wr(mem_wr), .cpu_irq(cpu_irq),
        .cpu_iack(cpu_iack), .cpu_iack_busy(cpu_iack_busy));
    icc_dev_model dev_u (.sys_clk(sys_clk), .rst_n(rst_n), .dev_cmd_valid(dev_cmd_valid), .dev_cmd(dev_cmd),
        .dev_data_ready(dev_data_ready), .n_bytes(n_bytes), .status_hi(status_hi), .status_lo(status_lo),
        .dev_data_valid(dev_data_valid), .dev_data(dev_data), .dev_status_valid(dev_status_valid),
        .dev_status(dev_status));
    ////////////////////////////////////////////////////////////////////////////
    // Descriptor memory answers one cycle after the request
    always @(posedge sys_clk)
    begin
        desc_ack <= 1'b0;
        if (desc_req === 1'b1 && !desc_ack)
        begin
            desc_ack   <= 1'b1;
            desc_word0 <= desc_tab[desc_addr[7:3]][63:32];
            desc_word1 <= desc_tab[desc_addr[7:3]][31:0];
            fetch_q.push_back(desc_addr);
        end
        if (mem_wr.valid === 1'b1)
        begin
            n_wr++;
            wr_addr = mem_wr.addr;
            wr_data = mem_wr.data;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge sys_clk);
            if (apb_rsp.pready === 1'b1)
                break;
        end
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        if (i == 50)
        begin
            n_fail++;
            $display("BAD %0t bus hang", $time);
            finish_test();
        end
    endtask : apb
    // Start the list and wait for the first interrupt, ending or program
    task automatic run_list;
        int i;
        fetch_q.delete();
        n_wr = 0;
        apb(1'b1, REG_LIST, 32'h0000_0100);
        apb(1'b1, REG_CTRL, 32'h0000_5A01);
        for (i = 0; i < 300 && cpu_irq !== 1'b1; i++)
            @(posedge sys_clk);
        if (i == 300)
        begin
            n_fail++;
            $display("BAD %0t no interrupt", $time);
            finish_test();
        end
    endtask : run_list
    task automatic end_check(input logic [31:0] st1, input logic [23:0] last, input int n_fetch);
        apb(1'b0, REG_STAT1, 32'h0);
        `CHK(rd, st1)
        apb(1'b0, REG_STAT0, 32'h0);
        `CHK(rd, {8'h5A, last + 24'h00_0008})
        `CHK(fetch_q.size(), n_fetch)
        @(posedge sys_clk);
        cpu_iack <= 1'b1;
        @(posedge sys_clk);
        cpu_iack <= 1'b0;
        repeat (2) @(posedge sys_clk);
        `CHK(cpu_irq, 1'b0)
    endtask : end_check
    ////////////////////////////////////////////////////////////////////////////
    task automatic s_regs;
        apb(1'b0, REG_STATE, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, 8'h14, 32'h0);
        `CHK(err, 1'b1)
    endtask : s_regs
    // Unit check with command chain set: no further fetch
    task automatic s_unit_check;
        desc_tab[0] = {8'h02, 24'h00_0800, 8'h02, 8'h00, 16'h0002};
        n_bytes = 8'h01;
        status_lo = 8'h38;
        run_list();
        `CHK(n_wr, 1)
        `CHK({wr_addr, wr_data}, {24'h00_0800, 8'hA0})
        end_check({8'h38, 8'h00, 16'h0001}, 24'h00_0100, 1);
    endtask : s_unit_check
    // Immediate command, modifier plus device end: chain sixteen bytes up
    task automatic s_modifier;
        desc_tab[0] = {8'h83, 24'h00_0000, 8'h02, 8'h00, 16'h0001};
        desc_tab[2] = {8'h03, 24'h00_0000, 8'h00, 8'h00, 16'h0001};
        n_bytes = 8'h00;
        status_hi = 8'h70;
        status_lo = 8'h30;
        run_list();
        `CHK(fetch_q[1], 24'h00_0110)
        `CHK(dev_cmd, 8'h03)
        end_check({8'h30, 8'h00, 16'h0001}, 24'h00_0110, 2);
    endtask : s_modifier
    // Skipped read above the memory top still chains; the next read stores
    task automatic s_skip;
        desc_tab[0] = {8'h02, 24'h00_3000, 8'h0A, 8'h00, 16'h0002};
        desc_tab[1] = {8'h02, 24'h00_0900, 8'h00, 8'h00, 16'h0002};
        n_bytes = 8'h02;
        status_lo = 8'h30;
        run_list();
        `CHK(n_wr, 2)
        `CHK({wr_addr, wr_data}, {24'h00_0901, 8'hA1})
        end_check({8'h30, 8'h00, 16'h0000}, 24'h00_0108, 2);
    endtask : s_skip
    // Data chaining with a program interrupt and an acknowledge stall
    task automatic s_dchain;
        int i;
        desc_tab[0] = {8'h02, 24'h00_0A00, 8'h11, 8'h00, 16'h0002};
        desc_tab[1] = {8'h00, 24'h00_0B00, 8'h00, 8'h00, 16'h0001};
        n_bytes = 8'h03;
        status_lo = 8'h30;
        run_list();
        cpu_iack_busy <= 1'b1;
        apb(1'b0, REG_STAT1, 32'h0);
        `CHK(rd, 32'h0001_0000)
        apb(1'b0, REG_STAT0, 32'h0);
        `CHK(rd, {8'h5A, 24'h00_0110})
        `CHK(n_wr, 2)
        cpu_iack_busy <= 1'b0;
        for (i = 0; i < 20; i++)
        begin
            apb(1'b0, REG_STATE, 32'h0);
            if (rd[2] === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_fail++;
            $display("BAD %0t no ending", $time);
            finish_test();
        end
        `CHK(dev_cmd, 8'h02)
        `CHK(n_wr, 3)
        `CHK({wr_addr, wr_data}, {24'h00_0B00, 8'hA2})
        end_check({8'h30, 8'h01, 16'h0000}, 24'h00_0108, 2);
    endtask : s_dchain
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        s_regs();
        s_unit_check();
        s_modifier();
        s_skip();
        s_dchain();
        finish_test();
    end
endmodule : icc_chain_ctrl_tb
